// [pinstrap_config_latch.sv]
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none

module pinstrap_config_latch
    import pinstrap_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // strap sensing, stored settings, source select and power
    input  wire strap_t      straps,
    input  wire cfg_t        nvm_cfg,
    input  wire logic        nvm_bypass_select,
    input  wire logic        aux_3v3_rail,
    // latched settings
    output var  cfg_t        cfg,
    output logic             captured,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    state_t s_q;
    state_t s_d;
    cfg_t   dec;
    logic   wr_commit;
    logic   recapture;

    // low resistance on the bypass pin reads as 1 here: straps rule
    strap_decode u_decode (
        .straps     (straps),
        .nvm_cfg    (nvm_cfg),
        .strap_mode (nvm_bypass_select),
        .dec        (dec)
    );

    // word view of a register; bit 32 flags a mapped address
    function automatic logic [32:0] reg_word(input cfg_t c, input state_t s,
                                             input logic strapped, input logic [7:0] a);
        logic [31:0] w;
        logic        hit;
        w   = 32'h0000_0000;
        hit = 1'b1;
        case (a)
            REG_STATUS: begin
                w[STAT_CAPTURED] = s.captured;
                w[STAT_STRAPPED] = strapped;
                w[STAT_RAIL]     = s.rail_q;
            end
            REG_SLEW_MODE: begin
                w[SLEW_LSB +: 3] = c.slew;
                w[MODE_ZLL]      = c.mode.zero_loadline;
                w[MODE_SHED]     = c.mode.phase_shed;
                w[MODE_PAIR]     = c.mode.pair_interleave;
                w[MODE_DAC]      = c.mode.dac_table;
            end
            REG_TRANSIENT: begin
                w[OVER_LSB +: 3]  = c.overshoot;
                w[UNDER_LSB +: 3] = c.undershoot;
            end
            REG_BOOT:        w[7:0] = c.boot;
            REG_RISE_FREQ: begin
                w[RISE_LSB +: 2] = c.rise_rate;
                w[FREQ_LSB +: 4] = c.freq;
            end
            REG_MAX_CURRENT: w[7:0] = c.max_current;
            REG_LIMIT_RAMP: begin
                w[LIMIT_LSB +: 4] = c.phase_limit;
                w[RAMP_LSB +: 3]  = c.ramp;
            end
            REG_BUS_ADDR:    w[3:0] = c.bus_addr;
            default:         hit = 1'b0;
        endcase
        return {hit, w};
    endfunction

    // byte-lane merge of a write onto the current word
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // writable fields taken back from a merged word; status and address are read-only
    function automatic cfg_t word_to_cfg(input cfg_t c, input logic [7:0] a,
                                         input logic [31:0] w);
        cfg_t n;
        n = c;
        case (a)
            REG_SLEW_MODE: begin
                n.slew                 = w[SLEW_LSB +: 3];
                n.mode.zero_loadline   = w[MODE_ZLL];
                n.mode.phase_shed      = w[MODE_SHED];
                n.mode.pair_interleave = w[MODE_PAIR];
                n.mode.dac_table       = w[MODE_DAC];
            end
            REG_TRANSIENT: begin
                n.overshoot  = w[OVER_LSB +: 3];
                n.undershoot = w[UNDER_LSB +: 3];
            end
            REG_BOOT:        n.boot = w[7:0];
            REG_RISE_FREQ: begin
                n.rise_rate = w[RISE_LSB +: 2];
                n.freq      = w[FREQ_LSB +: 4];
            end
            REG_MAX_CURRENT: n.max_current = w[7:0];
            REG_LIMIT_RAMP: begin
                n.phase_limit = w[LIMIT_LSB +: 4];
                n.ramp        = w[RAMP_LSB +: 3];
            end
            default:         n = c;
        endcase
        return n;
    endfunction

    // a write is held back while a capture is loading, so neither is lost
    assign wr_commit = s_q.aw_held && s_q.w_held && !s_q.bvalid && (s_q.st != ST_LATCH);
    assign recapture = wr_commit && (s_q.awaddr == REG_STATUS)
                       && s_q.wstrb[CTRL_RECAPTURE / 8] && s_q.wdata[CTRL_RECAPTURE];

    always_comb begin
        logic [32:0] rw;
        logic [32:0] ww;
        rw     = 33'h0_0000_0000;
        ww     = 33'h0_0000_0000;
        s_d    = s_q;
        s_d.rail_q = aux_3v3_rail;

        // capture sequencing
        case (s_q.st)
            ST_IDLE: begin
                if (aux_3v3_rail && !s_q.rail_q) begin
                    s_d.st = ST_LATCH;
                end
            end
            ST_LATCH: begin
                // every field, frequency and current included, loads in one edge
                s_d.cfg      = dec;
                s_d.captured = 1'b1;
                s_d.st       = ST_HOLD;
            end
            ST_HOLD: begin
                if (!aux_3v3_rail) begin
                    s_d.st = ST_IDLE;
                end else if (recapture) begin
                    s_d.st = ST_LATCH;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        // write address and data are taken in either order
        if (s_q.awready && s_axi_awvalid) begin
            s_d.aw_held = 1'b1;
            s_d.awready = 1'b0;
            s_d.awaddr  = s_axi_awaddr;
        end
        if (s_q.wready && s_axi_wvalid) begin
            s_d.w_held = 1'b1;
            s_d.wready = 1'b0;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
        end
        if (wr_commit) begin
            ww = reg_word(s_q.cfg, s_q, nvm_bypass_select, s_q.awaddr);
            // software may rewrite what was latched
            s_d.cfg = word_to_cfg(s_q.cfg, s_q.awaddr,
                                  merge_strb(ww[31:0], s_q.wdata, s_q.wstrb));
            s_d.bresp   = ww[32] ? RESP_OKAY : RESP_SLVERR;
            s_d.bvalid  = 1'b1;
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // reads answer on the same edge that takes the address
        if (s_q.arready && s_axi_arvalid) begin
            rw          = reg_word(s_q.cfg, s_q, nvm_bypass_select, s_axi_araddr);
            s_d.rdata   = rw[31:0];
            s_d.rresp   = rw[32] ? RESP_OKAY : RESP_SLVERR;
            s_d.rvalid  = 1'b1;
            s_d.arready = 1'b0;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q          <= '0;
            s_q.st       <= ST_IDLE;
            s_q.cfg      <= CFG_RESET;
            s_q.awready  <= 1'b1;
            s_q.wready   <= 1'b1;
            s_q.arready  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg           = s_q.cfg;
    assign captured      = s_q.captured;
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign s_axi_rvalid  = s_q.rvalid;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_rail_starts_latch: assert property (
        (s_q.st == ST_IDLE && aux_3v3_rail && !s_q.rail_q) |=> s_q.st == ST_LATCH ##1
        (s_q.cfg == $past(dec) && captured))
        else $error("rail rise did not load decoded settings");

    a_settings_held: assert property (
        (s_q.st == ST_HOLD && !wr_commit) |=> $stable(cfg))
        else $error("settings changed without capture or write");

    a_slew_mode_pins: assert property (
        (s_q.st == ST_LATCH && nvm_bypass_select) |=>
        (cfg.slew == $past(straps.slew_r) && cfg.mode == $past(straps.slew_v)))
        else $error("slew or mode not taken from strap");

    a_boot_code_bits: assert property (
        (s_q.st == ST_LATCH && nvm_bypass_select) |=>
        cfg.boot == {$past(straps.boot_v), $past(straps.boot_r), $past(straps.addr_r[0])})
        else $error("boot code assembled wrongly");

    a_freq_current_pair: assert property (
        (s_q.st == ST_LATCH && nvm_bypass_select) |=>
        (cfg.max_current == $past(straps.freq_v) && cfg.freq == {1'b0, $past(straps.freq_r)}))
        else $error("frequency and current not captured together");

    a_nvm_source_used: assert property (
        (s_q.st == ST_LATCH && !nvm_bypass_select) |=>
        (cfg.max_current == $past(nvm_cfg.max_current) && cfg.boot == $past(nvm_cfg.boot)))
        else $error("stored values not used with straps bypassed");

    a_addr_from_strap: assert property (
        (s_q.st == ST_LATCH) |=> cfg.bus_addr == $past(straps.addr_v))
        else $error("bus address not from strap");

    a_write_overwrites: assert property (
        (wr_commit && s_q.awaddr == REG_BOOT && s_q.wstrb[0]) |=>
        (cfg.boot == $past(s_q.wdata[7:0]) && s_axi_bvalid && s_axi_bresp == RESP_OKAY))
        else $error("boot write not applied");

    a_read_data_hold: assert property (
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read answer dropped before taken");

    a_write_answer_hold: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write answer dropped before taken");

    a_transient_levels: assert property (
        (s_q.st == ST_LATCH && nvm_bypass_select) |=>
        (cfg.overshoot == $past(straps.trans_r)
         && cfg.undershoot == $past(straps.trans_v)))
        else $error("transient reduction levels not taken from strap");

    a_rise_rate_bits: assert property (
        (s_q.st == ST_LATCH && nvm_bypass_select) |=>
        (cfg.rise_rate == $past(straps.addr_r[2:1])
         && cfg.boot[0] == $past(straps.addr_r[0])))
        else $error("rise rate or boot code low bit not taken from strap");

    a_limit_ramp_pins: assert property (
        (s_q.st == ST_LATCH && nvm_bypass_select) |=>
        (cfg.phase_limit == {$past(straps.limit_v[2]), $past(straps.limit_r)}
         && cfg.ramp == {1'b0, $past(straps.limit_v[1:0])}))
        else $error("current limit or ramp not taken from strap");

    a_captured_sticks: assert property (
        captured |=> captured)
        else $error("capture flag dropped");

    a_status_mode_bit: assert property (
        (s_q.arready && s_axi_arvalid && s_axi_araddr == REG_STATUS) |=>
        (s_axi_rdata[STAT_STRAPPED] == $past(nvm_bypass_select)
         && s_axi_rresp == RESP_OKAY))
        else $error("status read does not show strap mode");

    c_capture_strap: cover property (s_q.st == ST_LATCH && nvm_bypass_select);
    c_capture_nvm: cover property (s_q.st == ST_LATCH && !nvm_bypass_select);
    c_write_done: cover property (wr_commit ##1 s_axi_bvalid);
    c_recapture: cover property (recapture ##1 s_q.st == ST_LATCH);
    c_rail_drop: cover property (s_q.st == ST_HOLD && !aux_3v3_rail);

endmodule

`default_nettype wire

// [pinstrap_pkg.sv]
`default_nettype none

package pinstrap_pkg;

    // operating mode bits carried by the slew/mode strap voltage
    typedef struct packed {
        logic dac_table;        // 1: first voltage table variant
        logic pair_interleave;  // 1: phases 1/3 and 2/4 paired
        logic phase_shed;       // 1: dynamic phase add/drop enabled
        logic zero_loadline;    // 1: zero load-line
    } mode_t;

    // raw codes from the strap sensing stage: _r resistor code, _v voltage code
    typedef struct packed {
        logic [2:0] slew_r;
        logic [3:0] slew_v;
        logic [2:0] trans_r;
        logic [2:0] trans_v;
        logic [2:0] boot_r;
        logic [3:0] boot_v;
        logic [2:0] addr_r;
        logic [3:0] addr_v;
        logic [2:0] freq_r;
        logic [7:0] freq_v;
        logic [2:0] limit_r;
        logic [2:0] limit_v;
    } strap_t;

    typedef struct packed {
        logic [2:0] slew;
        mode_t      mode;
        logic [2:0] overshoot;
        logic [2:0] undershoot;
        logic [7:0] boot;
        logic [1:0] rise_rate;
        logic [3:0] freq;
        logic [7:0] max_current;
        logic [3:0] phase_limit;
        logic [2:0] ramp;
        logic [3:0] bus_addr;
    } cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_LATCH = 3'b010,
        ST_HOLD  = 3'b100
    } cap_state_t;

    // register byte offsets
    localparam logic [7:0] REG_STATUS      = 8'h00;
    localparam logic [7:0] REG_SLEW_MODE   = 8'h04;
    localparam logic [7:0] REG_TRANSIENT   = 8'h08;
    localparam logic [7:0] REG_BOOT        = 8'h0C;
    localparam logic [7:0] REG_RISE_FREQ   = 8'h10;
    localparam logic [7:0] REG_MAX_CURRENT = 8'h14;
    localparam logic [7:0] REG_LIMIT_RAMP  = 8'h18;
    localparam logic [7:0] REG_BUS_ADDR    = 8'h1C;

    // field positions
    localparam int STAT_CAPTURED  = 0;
    localparam int STAT_STRAPPED  = 1;
    localparam int STAT_RAIL      = 2;
    localparam int CTRL_RECAPTURE = 8;
    localparam int SLEW_LSB       = 0;
    localparam int MODE_ZLL       = 3;
    localparam int MODE_SHED      = 4;
    localparam int MODE_PAIR      = 6;
    localparam int MODE_DAC       = 7;
    localparam int OVER_LSB       = 0;
    localparam int UNDER_LSB      = 4;
    localparam int RISE_LSB       = 0;
    localparam int FREQ_LSB       = 4;
    localparam int LIMIT_LSB      = 0;
    localparam int RAMP_LSB       = 8;

    // reset image of the settings, matching the stored defaults
    localparam cfg_t CFG_RESET = '{
        slew: 3'h1, mode: '{dac_table: 1'b1, pair_interleave: 1'b0,
        phase_shed: 1'b0, zero_loadline: 1'b1},
        overshoot: 3'h7, undershoot: 3'h7, boot: 8'h97, rise_rate: 2'h0,
        freq: 4'h2, max_current: 8'h78, phase_limit: 4'h8, ramp: 3'h6,
        bus_addr: 4'h0};

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // whole state of the latch block
    typedef struct packed {
        cap_state_t  st;
        logic        rail_q;
        logic        captured;
        cfg_t        cfg;
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } state_t;

endpackage

`default_nettype wire

// [strap_decode.sv]
`default_nettype none

module strap_decode
    import pinstrap_pkg::*;
(
    // codes from the sensing stage, stored settings and strap mode select
    input  wire strap_t straps,
    input  wire cfg_t   nvm_cfg,
    input  wire logic   strap_mode,
    // decoded settings
    output var  cfg_t   dec
);

    always_comb begin
        dec = nvm_cfg;
        if (strap_mode) begin
            dec.slew                 = straps.slew_r;
            dec.mode.dac_table       = straps.slew_v[3];
            dec.mode.pair_interleave = straps.slew_v[2];
            dec.mode.phase_shed      = straps.slew_v[1];
            dec.mode.zero_loadline   = straps.slew_v[0];
            // code 0 is the off setting for both levels
            dec.overshoot            = straps.trans_r;
            dec.undershoot           = straps.trans_v;
            dec.boot[7:4]            = straps.boot_v;
            dec.boot[3:1]            = straps.boot_r;
            dec.boot[0]              = straps.addr_r[0];
            dec.rise_rate            = straps.addr_r[2:1];
            // straps reach only the lower eight of sixteen frequency codes
            dec.freq                 = {1'b0, straps.freq_r};
            dec.max_current          = straps.freq_v;
            dec.phase_limit          = {straps.limit_v[2], straps.limit_r};
            dec.ramp                 = {1'b0, straps.limit_v[1:0]};
        end
        // no stored address exists, so the strap always decides
        dec.bus_addr = straps.addr_v;
    end

endmodule

`default_nettype wire

// [strap_source.sv]
`default_nettype none

module strap_source
    import pinstrap_pkg::*;
(
    // control from the bench
    input  wire logic   aclk,
    input  wire logic   sel,
    input  wire logic   rail_on,
    // sensed codes and rail
    output var  strap_t straps,
    output logic        aux_3v3_rail
);
    timeunit 1ns;
    timeprecision 1ps;

    // two fixed divider sets; the sensing stage hands codes over as steady levels
    // one clocked process drives both outputs, so each has a single driver
    localparam strap_t SET_A = strap_t'(44'h5C3_96E1_7B24);
    localparam strap_t SET_B = strap_t'(44'hA3C_691E_84DB);

    always @(posedge aclk) begin
        straps       <= sel ? SET_B : SET_A;
        aux_3v3_rail <= rail_on;
    end
endmodule

`default_nettype wire

// [tb_top.sv]
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
    $display("[FAIL] %0t mismatch", $time); n_mismatch++; end end

module tb_top
    import pinstrap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic sel = 1'b0;
    logic rail_on = 1'b0;
    logic bypass = 1'b1;
    strap_t straps;
    logic rail;
    cfg_t nvm = cfg_t'(46'h2A5C_3E91_7B4D);
    cfg_t cfg;
    cfg_t e;
    logic captured;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int n_mismatch = 0;
    int compares = 0;

    always #2.5 aclk = ~aclk;

    strap_source u_src (.aclk(aclk), .sel(sel), .rail_on(rail_on), .straps(straps),
        .aux_3v3_rail(rail));

    pinstrap_config_latch u_dut (.aclk(aclk), .aresetn(aresetn), .straps(straps),
        .nvm_cfg(nvm), .nvm_bypass_select(bypass), .aux_3v3_rail(rail), .cfg(cfg),
        .captured(captured), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // expected settings, built field by field from the raw codes
    function automatic cfg_t decode(input strap_t s);
        cfg_t c;
        c.slew = s.slew_r;
        c.mode = mode_t'(s.slew_v);
        c.overshoot = s.trans_r;
        c.undershoot = s.trans_v;
        c.boot = {s.boot_v, s.boot_r, s.addr_r[0]};
        c.rise_rate = s.addr_r[2:1];
        c.freq = {1'b0, s.freq_r};
        c.max_current = s.freq_v;
        c.phase_limit = {s.limit_v[2], s.limit_r};
        c.ramp = {1'b0, s.limit_v[1:0]};
        c.bus_addr = s.addr_v;
        return c;
    endfunction

    task automatic finish_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // a new rail rise, or the recapture bit, loads two edges later
    task automatic rail_cycle();
        rail_on <= 1'b0;
        repeat (3) @(posedge aclk);
        rail_on <= 1'b1;
        repeat (5) @(posedge aclk);
    endtask

    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        `CHK(cfg, CFG_RESET)
        `CHK(captured, 1'b0)
        rail_cycle();
        `CHK(captured, 1'b1)
        `CHK(cfg, decode(straps))
        `CHK(cfg.boot, {straps.boot_v, straps.boot_r, straps.addr_r[0]})
        `CHK(cfg.rise_rate, straps.addr_r[2:1])
        `CHK(cfg.bus_addr, straps.addr_v)
        `CHK({cfg.freq, cfg.max_current}, {1'b0, straps.freq_r, straps.freq_v})
        `CHK(cfg.phase_limit, {straps.limit_v[2], straps.limit_r})
        e = cfg;
        sel <= 1'b1;
        repeat (6) @(posedge aclk);
        `CHK(cfg, e)
        axi_write(REG_STATUS, 32'h0000_0100, 4'b0010);
        repeat (4) @(posedge aclk);
        `CHK(cfg, decode(straps))
        axi_read(REG_STATUS);
        `CHK(rd[2:0], 3'b111)
        axi_write(REG_BOOT, 32'h0000_005A, 4'hF);
        `CHK(resp, RESP_OKAY)
        `CHK(cfg.boot, 8'h5A)
        axi_write(REG_SLEW_MODE, 32'hFFFF_FFC5, 4'b0001);
        `CHK({cfg.slew, cfg.mode}, {3'h5, 4'b1100})
        axi_read(REG_SLEW_MODE);
        `CHK(rd[7:0], 8'hC5)
        e = cfg;
        axi_write(REG_BUS_ADDR, 32'h0000_000F, 4'hF);
        `CHK(resp, RESP_OKAY)
        `CHK(cfg, e)
        axi_write(8'h40, 32'hFFFF_FFFF, 4'hF);
        `CHK(resp, RESP_SLVERR)
        `CHK(cfg, e)
        axi_read(8'h40);
        `CHK(resp, RESP_SLVERR)
        bypass <= 1'b0;
        sel <= 1'b0;
        rail_cycle();
        e = nvm;
        e.bus_addr = straps.addr_v;
        `CHK(cfg, e)
        axi_read(REG_STATUS);
        `CHK(rd[1], 1'b0)
        finish_test();
    end
endmodule

`default_nettype wire
